// file: verilog/sdlc_rx_result_registers.sv
// Receive result registers of the serial link unit, reached over APB.
// Assumes frame engine signals on clk; APB master follows the usual protocol.
//
// Decided for this implementation: register access over APB.
`timescale 1ns/1ps
`default_nettype none
module sdlc_rx_result_registers (
	input  wire logic        clk,
	input  wire logic        rstn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        frameDone,
	input  wire logic [7:0]  frameLength,
	input  wire logic [7:0]  frameControl,
	input  wire logic [7:0]  stateCounter,
	output logic             receiveBufferEmptyFlag
);
	logic [7:0]  fieldLength_q;
	logic [7:0]  controlByte_q;
	logic        rbe_q;
	logic [7:0]  stateView_q;
	logic [31:0] prdata_q;
	logic [31:0] prdata_d;
	logic        slverr_q;
	logic        slverr_d;
	wire         setupPhase = psel && !penable;
	wire         accessPhase = psel && penable;
	wire         hitLen = (paddr == rx_result_pkg::RX_FIELD_LENGTH_ADDR);
	wire         hitCtl = (paddr == rx_result_pkg::RX_CONTROL_BYTE_ADDR);
	wire         hitCnt = (paddr == rx_result_pkg::SERIAL_STATE_COUNTER_ADDR);
	wire         hitSts = (paddr == rx_result_pkg::RX_STATUS_ADDR);
	wire         mapped = hitLen || hitCtl || hitCnt || hitSts;
	// Only the status word accepts writes; others refuse with an error
	wire         writeOk = hitSts;
	wire         rbeSet = accessPhase && pwrite && hitSts && pwdata[rx_result_pkg::RBE_BIT];

	rx_result_capture capture (
		.clk           (clk),
		.rstn          (rstn),
		.frameDone     (frameDone),
		.frameLength   (frameLength),
		.frameControl  (frameControl),
		.rbeSet        (rbeSet),
		.fieldLength_q (fieldLength_q),
		.controlByte_q (controlByte_q),
		.rbe_q         (rbe_q)
	);

	// State counter sampled each cycle; owned by the unit, never written
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			stateView_q <= rx_result_pkg::BYTE_RESET;
		end else begin
			stateView_q <= stateCounter;
		end
	end

	// Read data picked in setup so it comes from a flop in access
	always_comb begin
		prdata_d = 32'h0000_0000;
		if (hitLen) begin
			prdata_d = {24'h00_0000, fieldLength_q};
		end else if (hitCtl) begin
			prdata_d = {24'h00_0000, controlByte_q};
		end else if (hitCnt) begin
			prdata_d = {24'h00_0000, stateView_q};
		end else if (hitSts) begin
			prdata_d[rx_result_pkg::RBE_BIT] = rbe_q;
		end
		// Writes to control byte and state counter are refused
		slverr_d = !mapped || (pwrite && !writeOk);
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			prdata_q <= 32'h0000_0000;
			slverr_q <= 1'b0;
		end else if (setupPhase) begin
			prdata_q <= pwrite ? 32'h0000_0000 : prdata_d;
			slverr_q <= slverr_d;
		end
	end

	assign pready = 1'b1;
	assign prdata = prdata_q;
	assign pslverr = accessPhase && slverr_q;
	assign receiveBufferEmptyFlag = rbe_q;

	// Assertions
	property p_len_load;
		@(posedge clk) disable iff (!rstn)
		frameDone |=> (fieldLength_q == $past(frameLength));
	endproperty
	a_len_load: assert property (p_len_load) else $error("length not loaded");

	property p_len_zero;
		@(posedge clk) disable iff (!rstn)
		(frameDone && frameLength == 8'h00) |=> (fieldLength_q == 8'h00);
	endproperty
	a_len_zero: assert property (p_len_zero) else $error("zero length lost");

	property p_ctl_load;
		@(posedge clk) disable iff (!rstn)
		frameDone |=> (controlByte_q == $past(frameControl));
	endproperty
	a_ctl_load: assert property (p_ctl_load) else $error("control not loaded");

	property p_ctl_ro;
		@(posedge clk) disable iff (!rstn)
		(!frameDone) |=> $stable(controlByte_q);
	endproperty
	a_ctl_ro: assert property (p_ctl_ro) else $error("control byte changed");

	property p_ctl_werr;
		@(posedge clk) disable iff (!rstn)
		(setupPhase && pwrite && hitCtl) ##1 accessPhase |-> pslverr;
	endproperty
	a_ctl_werr: assert property (p_ctl_werr) else $error("write not refused");

	property p_cnt_view;
		@(posedge clk) disable iff (!rstn)
		1'b1 |=> (stateView_q == $past(stateCounter));
	endproperty
	a_cnt_view: assert property (p_cnt_view) else $error("counter view stale");

	property p_rbe_clr;
		@(posedge clk) disable iff (!rstn)
		frameDone |=> !rbe_q;
	endproperty
	a_rbe_clr: assert property (p_rbe_clr) else $error("flag not cleared");

	sequence s_set_only;
		rbeSet && !frameDone;
	endsequence
	property p_rbe_set;
		@(posedge clk) disable iff (!rstn)
		s_set_only |=> rbe_q;
	endproperty
	a_rbe_set: assert property (p_rbe_set) else $error("flag not set");

	property p_consistent;
		@(posedge clk) disable iff (!rstn)
		$fell(rbe_q) |-> (fieldLength_q == $past(frameLength));
	endproperty
	a_consistent: assert property (p_consistent) else $error("results late");

	property p_ctl_consistent;
		@(posedge clk) disable iff (!rstn)
		$fell(rbe_q) |-> (controlByte_q == $past(frameControl));
	endproperty
	a_ctl_consistent: assert property (p_ctl_consistent) else $error("control late");

	// Length changes only on a stored frame, never from the bus
	property p_len_hold;
		@(posedge clk) disable iff (!rstn)
		(!frameDone) |=> $stable(fieldLength_q);
	endproperty
	a_len_hold: assert property (p_len_hold) else $error("length changed");

	// Flag moves only on a software set or a frame
	property p_rbe_hold;
		@(posedge clk) disable iff (!rstn)
		(!frameDone && !rbeSet) |=> $stable(rbe_q);
	endproperty
	a_rbe_hold: assert property (p_rbe_hold) else $error("flag moved");

	// Reads: data seen in access is the register as it stood in setup
	sequence s_rd_len;
		(setupPhase && !pwrite && hitLen) ##1 accessPhase;
	endsequence
	property p_rd_len;
		@(posedge clk) disable iff (!rstn)
		s_rd_len |-> (prdata == {24'h00_0000, $past(fieldLength_q)});
	endproperty
	a_rd_len: assert property (p_rd_len) else $error("length read wrong");

	sequence s_rd_ctl;
		(setupPhase && !pwrite && hitCtl) ##1 accessPhase;
	endsequence
	property p_rd_ctl;
		@(posedge clk) disable iff (!rstn)
		s_rd_ctl |-> (prdata == {24'h00_0000, $past(controlByte_q)});
	endproperty
	a_rd_ctl: assert property (p_rd_ctl) else $error("control read wrong");

	sequence s_rd_cnt;
		(setupPhase && !pwrite && hitCnt) ##1 accessPhase;
	endsequence
	property p_rd_cnt;
		@(posedge clk) disable iff (!rstn)
		s_rd_cnt |-> (prdata == {24'h00_0000, $past(stateView_q)});
	endproperty
	a_rd_cnt: assert property (p_rd_cnt) else $error("counter read wrong");

	sequence s_rd_sts;
		(setupPhase && !pwrite && hitSts) ##1 accessPhase;
	endsequence
	property p_rd_sts;
		@(posedge clk) disable iff (!rstn)
		s_rd_sts |-> (prdata[rx_result_pkg::RBE_BIT] == $past(rbe_q));
	endproperty
	a_rd_sts: assert property (p_rd_sts) else $error("flag read wrong");

	// Length is owned by the unit, so a bus write is refused
	sequence s_wr_len;
		(setupPhase && pwrite && hitLen) ##1 accessPhase;
	endsequence
	property p_len_werr;
		@(posedge clk) disable iff (!rstn)
		s_wr_len |-> pslverr;
	endproperty
	a_len_werr: assert property (p_len_werr) else $error("length write taken");
endmodule
`default_nettype wire

// file: verilog/rx_result_pkg.sv
// Package for the receive result register bank.
// Assumes a 32-bit APB slave with byte addresses equal to register index times four.
package rx_result_pkg;
	// Register indices, byte address is index times four
	localparam logic [7:0] RX_CONTROL_BYTE_IDX      = 8'hCA;
	localparam logic [7:0] RX_FIELD_LENGTH_IDX      = 8'hCD;
	localparam logic [7:0] SERIAL_STATE_COUNTER_IDX = 8'hD9;
	localparam logic [7:0] RX_STATUS_IDX            = 8'hC8;
	localparam logic [11:0] RX_CONTROL_BYTE_ADDR      = {2'h0, RX_CONTROL_BYTE_IDX, 2'h0};
	localparam logic [11:0] RX_FIELD_LENGTH_ADDR      = {2'h0, RX_FIELD_LENGTH_IDX, 2'h0};
	localparam logic [11:0] SERIAL_STATE_COUNTER_ADDR = {2'h0, SERIAL_STATE_COUNTER_IDX, 2'h0};
	localparam logic [11:0] RX_STATUS_ADDR            = {2'h0, RX_STATUS_IDX, 2'h0};
	// Receive-buffer-empty flag position in the status word
	localparam int         RBE_BIT       = 6;
	localparam logic [7:0] BYTE_RESET    = 8'h00;
	localparam logic       RBE_RESET     = 1'b0;
endpackage

// file: verilog/rx_result_capture.sv
// Frame result capture: length, control byte and receive-buffer-empty flag.
// Assumes the frame engine pulses frameDone on the same clock.
`timescale 1ns/1ps
`default_nettype none
module rx_result_capture (
	input  wire logic       clk,
	input  wire logic       rstn,
	input  wire logic       frameDone,
	input  wire logic [7:0] frameLength,
	input  wire logic [7:0] frameControl,
	input  wire logic       rbeSet,
	output logic [7:0]      fieldLength_q,
	output logic [7:0]      controlByte_q,
	output logic            rbe_q
);
	// Results load on the same edge that clears the flag, so both look consistent
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			fieldLength_q <= rx_result_pkg::BYTE_RESET;
			controlByte_q <= rx_result_pkg::BYTE_RESET;
		end else if (frameDone) begin
			fieldLength_q <= frameLength;
			controlByte_q <= frameControl;
		end
	end

	// Frame completion wins over a software set in the same cycle
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			rbe_q <= rx_result_pkg::RBE_RESET;
		end else if (frameDone) begin
			rbe_q <= 1'b0;
		end else if (rbeSet) begin
			rbe_q <= 1'b1;
		end
	end
endmodule
`default_nettype wire

// file: verif/frame_source_model.sv
// Frame engine stand-in: one-cycle frame-stored pulse with length and control.
// Assumes the bench raises start for one cycle per frame.
`timescale 1ns/1ps
`default_nettype none
module frame_source_model (
	input  wire logic       clk,
	input  wire logic       rstn,
	input  wire logic       start,
	input  wire logic [7:0] lenIn,
	input  wire logic [7:0] ctlIn,
	output logic            frameDone,
	output logic [7:0]      frameLength,
	output logic [7:0]      frameControl
);
	// Values toggle outside the pulse so a stale capture shows up
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			frameDone <= 1'b0;
			frameLength <= 8'h00;
			frameControl <= 8'h00;
		end else begin
			frameDone <= start;
			frameLength <= start ? lenIn : ~frameLength;
			frameControl <= start ? ctlIn : ~frameControl;
		end
	end
endmodule
`default_nettype wire

// file: verif/sdlc_rx_result_registers_tb_top.sv
// Bench: APB master notes expectations, scoreboard compares completed transfers.
// Assumes the frame source model and a zero-wait APB slave.
`timescale 1ns/1ps
`default_nettype none
module sdlc_rx_result_registers_tb_top;
	logic        clk = 0, rstn = 0, psel = 0, penable = 0, pwrite = 0, start = 0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata;
	logic        pready, pslverr, frameDone, flag;
	logic [7:0]  frameLength, frameControl, len = 0, ctl = 0, cnt = 0, l, c;
	logic [33:0] notes[$], e;
	int          nErrors = 0, nChecks = 0;
	sdlc_rx_result_registers DUT (.clk(clk), .rstn(rstn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .frameDone(frameDone), .frameLength(frameLength),
		.frameControl(frameControl), .stateCounter(cnt), .receiveBufferEmptyFlag(flag));
	frame_source_model src (.clk(clk), .rstn(rstn), .start(start), .lenIn(len),
		.ctlIn(ctl), .frameDone(frameDone), .frameLength(frameLength),
		.frameControl(frameControl));
	initial begin
		forever #5 clk = ~clk;
	end
	task automatic check(input logic [31:0] s, input logic [31:0] w);
		nChecks++;
		if (s !== w) begin
			nErrors++;
			$display("wrong value at %0t: got %h want %h", $time, s, w);
		end
	endtask
	task automatic completeRun();
		$display("checks %0d errors %0d", nChecks, nErrors);
		if (nErrors == 0 && nChecks > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	// One transfer; the note carries read flag, error and data
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
		input logic [31:0] x, input logic r);
		int k;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		notes.push_back({~w, r, x});
		@(posedge clk);
		penable <= 1'b1;
		for (k = 0; k < 16; k++) begin
			@(posedge clk);
			if (pready === 1'b1) break;
		end
		if (k == 16) begin
			nErrors++;
			completeRun();
		end
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
	endtask
	task automatic frame();
		start <= 1'b1;
		len <= l;
		ctl <= c;
		@(posedge clk);
		start <= 1'b0;
		repeat (2) @(posedge clk);
		check({31'h0, flag}, 32'h0);
	endtask
	// Scoreboard, popping at each access edge
	always @(posedge clk) begin
		if (psel && penable && pready === 1'b1) begin
			e = notes.pop_front();
			if (e[33]) check(prdata, e[31:0]);
			check({31'h0, pslverr}, {31'h0, e[32]});
		end
	end
	initial begin
		void'($urandom(39));
		repeat (5) @(posedge clk);
		rstn <= 1'b1;
		@(posedge clk);
		apb(0, rx_result_pkg::RX_STATUS_ADDR, 0, 0, 0);
		apb(0, rx_result_pkg::RX_FIELD_LENGTH_ADDR, 0, 0, 0);
		for (int i = 0; i < 4; i++) begin
			apb(1, rx_result_pkg::RX_STATUS_ADDR, 32'h40, 0, 0);
			check({31'h0, flag}, 32'h1);
			apb(0, rx_result_pkg::RX_STATUS_ADDR, 0, 32'h40, 0);
			l = (i == 0) ? 8'h00 : 8'($urandom);
			c = 8'($urandom);
			frame();
			// Writing zero to the flag has no effect
			apb(1, rx_result_pkg::RX_STATUS_ADDR, 32'h0, 0, 0);
			check({31'h0, flag}, 32'h0);
			apb(1, rx_result_pkg::RX_FIELD_LENGTH_ADDR, 32'hFF, 0, 1);
			apb(0, rx_result_pkg::RX_FIELD_LENGTH_ADDR, 0, {24'h0, l}, 0);
			apb(0, rx_result_pkg::RX_CONTROL_BYTE_ADDR, 0, {24'h0, c}, 0);
			apb(1, rx_result_pkg::RX_CONTROL_BYTE_ADDR, ~{24'h0, c}, 0, 1);
			apb(0, rx_result_pkg::RX_CONTROL_BYTE_ADDR, 0, {24'h0, c}, 0);
			cnt <= 8'($urandom);
			repeat (2) @(posedge clk);
			apb(0, rx_result_pkg::SERIAL_STATE_COUNTER_ADDR, 0, {24'h0, cnt}, 0);
		end
		apb(0, 12'h3FC, 0, 0, 1);
		completeRun();
	end
endmodule
`default_nettype wire
